// >>> rtl/sbda_clkdiv.sv
// Integer clock divider for one bus clock.
// Assumes DIV of at least 2 and at most 16.
`timescale 1ns/100ps
module sbda_clkdiv
  import sbda_pkg::*;
#(
  parameter int DIV = 2
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  sbda_div_if.src div_out
);

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic lvl;
    logic rise;
  } sbda_div_st_t;

  localparam logic [DIV_CNT_W-1:0] LAST = DIV_CNT_W'(DIV - 1);
  localparam logic [DIV_CNT_W-1:0] HALF = DIV_CNT_W'(DIV / 2);
  localparam logic [DIV_CNT_W-1:0] ONE = DIV_CNT_W'(1);

  sbda_div_st_t div_r;
  sbda_div_st_t div_nxt;

  always_comb begin
    div_nxt = div_r;
    if (div_r.cnt == LAST) begin
      div_nxt.cnt = '0;
    end else begin
      div_nxt.cnt = div_r.cnt + ONE;
    end
    div_nxt.lvl = (div_nxt.cnt < HALF);
    div_nxt.rise = (div_nxt.cnt == '0);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign div_out.clk_lvl = div_r.lvl;
  assign div_out.rise = div_r.rise;

endmodule

// >>> rtl/sbda_div_if.sv
// Divided clock level and its rising-edge tick.
// Driven by one divider, read by the arbiter.
`timescale 1ns/100ps
interface sbda_div_if;
  logic clk_lvl;
  logic rise;
  modport src (output clk_lvl, output rise);
  modport snk (input clk_lvl, input rise);
endinterface

// >>> rtl/sbda_pkg.sv
// Constants and types shared by the system bus and DMA arbiter.
// Assumes a 40 MHz system clock; all other bus clocks divide from it.
package sbda_pkg;

  // ---------------------------------------------------------------
  // Clock derivation
  // ---------------------------------------------------------------
  localparam int REF_HZ = 40_000_000;
  localparam int CPU16_HZ = 8_000_000;
  localparam int CPU8_HZ = 6_000_000;
  localparam int DMA_HZ = 4_000_000;
  localparam int DIV_CPU16 = REF_HZ / CPU16_HZ;
  localparam int DIV_CPU8 = REF_HZ / CPU8_HZ;
  localparam int DIV_DMA = REF_HZ / DMA_HZ;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int BANK_W = 4;
  localparam int LOC_W = 16;
  localparam int SYS_W = 20;
  localparam int BYTE_W = 8;
  localparam int NUM_SPARE = 4;
  localparam int NUM_BANKS = 4;
  localparam int DIV_CNT_W = 4;
  localparam logic [1:0] FLOPPY_STRETCH = 2'h2;
  localparam logic [1:0] STRETCH_DONE = 2'h0;
  localparam logic [1:0] STRETCH_STEP = 2'h1;
  localparam logic [2:0] SEL_CPU8_BANK = 3'h4;

  // ---------------------------------------------------------------
  // Bus ownership states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OWN_CPU16,
    OWN_CPU8,
    SWAP_TO8,
    SWAP_TO16,
    DMA_WAIT,
    OWN_DMA
  } sbda_own_t;

  typedef struct packed {
    sbda_own_t own;
    sbda_own_t prev;
    logic run16;
    logic run8;
    logic hold_ack;
    logic master_drv;
    logic sys_drv;
    logic xfer_en;
    logic io_en;
    logic cas_dreq;
    logic [NUM_SPARE-1:0] spare_dreq;
    logic [BYTE_W-1:0] hi;
    logic [BANK_W-1:0] cpu8_bank;
    logic [NUM_BANKS-1:0][BANK_W-1:0] dma_bank;
    logic [SYS_W-1:0] addr;
    logic [1:0] stretch;
    logic rdy16;
    logic rdy_dma;
    logic clk16;
    logic clk8;
    logic clkd;
  } sbda_st_t;

  localparam sbda_st_t ST_RST = '0;

endpackage

// >>> rtl/sbda_top.sv
// System bus ownership arbiter with DMA cascade, bank extension,
// bus clock generation and DMA ready stretching.
// Assumes all inputs synchronous to clk_sys_in; address decode is outside.
`timescale 1ns/100ps
module sbda_top
  import sbda_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cpu16_idle_in,
  input wire logic cpu16_handover_sel_in,
  input wire logic [SYS_W-1:0] cpu16_addr_in,
  input wire logic cpu8_idle_in,
  input wire logic cpu8_io_req_in,
  input wire logic [LOC_W-1:0] cpu8_addr_in,
  input wire logic irq_in,
  input wire logic master_hold_req_in,
  input wire logic slave_hold_req_in,
  input wire logic cascade_dack_in,
  input wire logic [NUM_SPARE-1:0] spare_dack_in,
  input wire logic [NUM_SPARE-1:0] spare_passive_in,
  input wire logic [NUM_SPARE-1:0] offboard_req_in,
  input wire logic dma_high_address_strobe_in,
  input wire logic [BYTE_W-1:0] dma_data_in,
  input wire logic [BYTE_W-1:0] dma_addr_lo_in,
  input wire logic [1:0] dma_chan_in,
  input wire logic dma_refresh_in,
  input wire logic bank_wr_in,
  input wire logic [2:0] bank_sel_in,
  input wire logic [BANK_W-1:0] bank_data_in,
  input wire logic slow_io_in,
  input wire logic bus_wait_extend_in,
  input wire logic floppy_cycle_in,
  output logic cpu16_run_out,
  output logic cpu8_run_out,
  output logic master_hold_ack_out,
  output logic master_drive_en_out,
  output logic sys_drive_en_out,
  output logic data_xfer_en_out,
  output logic onboard_io_en_out,
  output logic cascade_dreq_out,
  output logic [NUM_SPARE-1:0] spare_dreq_out,
  output logic [SYS_W-1:0] sys_addr_out,
  output logic cpu16_ready_out,
  output logic dma_ready_out,
  output logic cpu16_clk_out,
  output logic cpu8_clk_out,
  output logic dma_clk_out
);

  // ---------------------------------------------------------------
  // Bus clock dividers
  // ---------------------------------------------------------------
  sbda_div_if div16_if ();
  sbda_div_if div8_if ();
  sbda_div_if divd_if ();

  sbda_clkdiv #(.DIV(DIV_CPU16)) u_div16 (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .div_out(div16_if)
  );
  sbda_clkdiv #(.DIV(DIV_CPU8)) u_div8 (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .div_out(div8_if)
  );
  sbda_clkdiv #(.DIV(DIV_DMA)) u_divd (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .div_out(divd_if)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sbda_st_t st_r;
  sbda_st_t st_nxt;
  logic passive_grant;
  logic dma_own;

  always_comb begin
    st_nxt = st_r;
    passive_grant = |(spare_dack_in & spare_passive_in);

    // Ownership sequencing, hold request checked first
    unique case (st_r.own)
      OWN_CPU16: begin
        if (master_hold_req_in) begin
          st_nxt.prev = OWN_CPU16;
          st_nxt.own = DMA_WAIT;
        end else if (cpu16_handover_sel_in) begin
          st_nxt.own = SWAP_TO8;
        end
      end
      OWN_CPU8: begin
        if (master_hold_req_in) begin
          st_nxt.prev = OWN_CPU8;
          st_nxt.own = DMA_WAIT;
        end else if (cpu8_io_req_in || irq_in) begin
          st_nxt.own = SWAP_TO16;
        end
      end
      SWAP_TO8: begin
        if (master_hold_req_in) begin
          st_nxt.prev = OWN_CPU8;
          st_nxt.own = DMA_WAIT;
        end else if (cpu16_idle_in) begin
          st_nxt.own = OWN_CPU8;
        end
      end
      SWAP_TO16: begin
        if (master_hold_req_in) begin
          st_nxt.prev = OWN_CPU16;
          st_nxt.own = DMA_WAIT;
        end else if (cpu8_idle_in) begin
          st_nxt.own = OWN_CPU16;
        end
      end
      DMA_WAIT: begin
        if (!master_hold_req_in) begin
          st_nxt.own = st_r.prev;
        end else if (cpu16_idle_in && cpu8_idle_in) begin
          st_nxt.own = OWN_DMA;
        end
      end
      OWN_DMA: begin
        if (!master_hold_req_in) begin
          st_nxt.own = st_r.prev;
        end
      end
      default: begin
        st_nxt.own = OWN_CPU16;
      end
    endcase

    dma_own = (st_nxt.own == OWN_DMA);
    st_nxt.run16 = (st_nxt.own == OWN_CPU16);
    st_nxt.run8 = (st_nxt.own == OWN_CPU8);
    st_nxt.hold_ack = dma_own;
    st_nxt.master_drv = dma_own && !cascade_dack_in;
    st_nxt.sys_drv = (st_nxt.run16 || st_nxt.run8 || dma_own)
      && !(dma_own && passive_grant);
    st_nxt.xfer_en = !(dma_own && dma_refresh_in);
    st_nxt.io_en = !(dma_own && passive_grant);

    // Request paths into the DMA controllers
    st_nxt.cas_dreq = slave_hold_req_in;
    st_nxt.spare_dreq = offboard_req_in;

    // High address byte latch
    if (dma_high_address_strobe_in) begin
      st_nxt.hi = dma_data_in;
    end

    // Bank registers
    if (bank_wr_in) begin
      if (bank_sel_in == SEL_CPU8_BANK) begin
        st_nxt.cpu8_bank = bank_data_in;
      end else if (bank_sel_in < SEL_CPU8_BANK) begin
        st_nxt.dma_bank[bank_sel_in[1:0]] = bank_data_in;
      end
    end

    // System address by owner
    unique case (st_nxt.own)
      OWN_CPU16: st_nxt.addr = cpu16_addr_in;
      OWN_CPU8: st_nxt.addr = {st_r.cpu8_bank, cpu8_addr_in};
      OWN_DMA: st_nxt.addr = {st_r.dma_bank[dma_chan_in], st_r.hi,
        dma_addr_lo_in};
      default: st_nxt.addr = st_r.addr;
    endcase

    // Floppy stretch counter: 2, 1, 0 on DMA clock edges
    if (floppy_cycle_in && st_r.stretch == STRETCH_DONE) begin
      st_nxt.stretch = FLOPPY_STRETCH;
    end else if (st_r.stretch != STRETCH_DONE && divd_if.rise) begin
      st_nxt.stretch = st_r.stretch - STRETCH_STEP;
    end

    st_nxt.rdy16 = !slow_io_in;
    st_nxt.rdy_dma = (st_nxt.stretch == STRETCH_DONE) && !slow_io_in
      && !bus_wait_extend_in;

    st_nxt.clk16 = div16_if.clk_lvl;
    st_nxt.clk8 = div8_if.clk_lvl;
    st_nxt.clkd = divd_if.clk_lvl;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cpu16_run_out = st_r.run16;
  assign cpu8_run_out = st_r.run8;
  assign master_hold_ack_out = st_r.hold_ack;
  assign master_drive_en_out = st_r.master_drv;
  assign sys_drive_en_out = st_r.sys_drv;
  assign data_xfer_en_out = st_r.xfer_en;
  assign onboard_io_en_out = st_r.io_en;
  assign cascade_dreq_out = st_r.cas_dreq;
  assign spare_dreq_out = st_r.spare_dreq;
  assign sys_addr_out = st_r.addr;
  assign cpu16_ready_out = st_r.rdy16;
  assign dma_ready_out = st_r.rdy_dma;
  assign cpu16_clk_out = st_r.clk16;
  assign cpu8_clk_out = st_r.clk8;
  assign dma_clk_out = st_r.clkd;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  // Expected owner after DMA, tracked from the ports
  logic last16_r;
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      last16_r <= 1'b1;
    end else if (cpu16_run_out) begin
      last16_r <= !(cpu16_handover_sel_in && !master_hold_req_in);
    end else if (cpu8_run_out) begin
      last16_r <= (cpu8_io_req_in || irq_in) && !master_hold_req_in;
    end
  end

  hold_ack_gate_a: assert property (
    $rose(master_hold_ack_out) |-> $past(cpu16_idle_in)
      && $past(cpu8_idle_in) && !cpu16_run_out && !cpu8_run_out)
    else $error("hold acknowledged before processors cleared");

  one_owner_a: assert property (
    $onehot0({cpu16_run_out, cpu8_run_out, master_hold_ack_out}))
    else $error("more than one bus owner");

  cascade_follow_a: assert property (
    $fell(slave_hold_req_in) |=> !cascade_dreq_out ##0
      $past(cascade_dreq_out))
    else $error("cascade request did not follow slave hold");

  hold_release_a: assert property (
    master_hold_ack_out && !master_hold_req_in
      |=> !master_hold_ack_out && (cpu16_run_out || cpu8_run_out))
    else $error("bus not returned after hold drop");

  return_prev_a: assert property (
    $fell(master_hold_ack_out) |->
      cpu16_run_out == last16_r && cpu8_run_out == !last16_r)
    else $error("bus returned to wrong processor");

  floppy_wait_a: assert property (
    floppy_cycle_in && st_r.stretch == STRETCH_DONE
      |=> (st_r.stretch != STRETCH_DONE)[*8] ##1
      (st_r.stretch != STRETCH_DONE)[*3] ##[1:10]
      (st_r.stretch == STRETCH_DONE))
    else $error("floppy stretch length wrong");

  refresh_nodata_a: assert property (
    master_hold_ack_out && master_hold_req_in && dma_refresh_in
      |=> !data_xfer_en_out && master_hold_ack_out)
    else $error("data transfer enabled during refresh");

  dma_addr_a: assert property (
    master_hold_ack_out && master_hold_req_in && !bank_wr_in
      |=> sys_addr_out == {$past(st_r.dma_bank[dma_chan_in]),
      $past(st_r.hi), $past(dma_addr_lo_in)})
    else $error("DMA system address wrong");

  irq_swap_a: assert property (
    cpu8_run_out && (irq_in || cpu8_io_req_in) && !master_hold_req_in
      |=> !cpu8_run_out && !cpu16_run_out)
    else $error("eight-bit CPU kept bus on swap");

  master_drive_a: assert property (
    master_drive_en_out |-> master_hold_ack_out && !$past(cascade_dack_in))
    else $error("master drives during cascade");

  passive_io_a: assert property (
    master_hold_req_in && master_hold_ack_out
      && |(spare_dack_in & spare_passive_in)
      |=> !onboard_io_en_out && !sys_drive_en_out)
    else $error("on-board I/O open to passive master");

endmodule

// >>> verification/sbda_cpu_model.sv
// Stand-in for both processors' bus release acknowledges.
// Assumes run inputs come from the arbiter; lag_in sets how slowly
// each processor ends its cycle and floats its drivers.
`timescale 1ns/100ps
module sbda_cpu_model (
  input wire logic clk_sys_in,
  input wire logic run16_in,
  input wire logic run8_in,
  input wire logic [1:0] lag_in,
  output logic idle16_out,
  output logic idle8_out
);
  logic [3:0] h16_r = 4'h0;
  logic [3:0] h8_r = 4'h0;
  logic [3:0] msk;
  // ---------------------------------------------------------------
  // Idle only once run has been low for lag_in+1 edges
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    h16_r <= {h16_r[2:0], ~run16_in};
    h8_r <= {h8_r[2:0], ~run8_in};
  end
  assign msk = (4'h2 << lag_in) - 4'h1;
  assign idle16_out = ~run16_in & (&(h16_r | ~msk));
  assign idle8_out = ~run8_in & (&(h8_r | ~msk));
endmodule

// >>> verification/tb.sv
// Self-checking bench for the system bus and DMA arbiter.
// Assumes the processor stand-in answers the run outputs.
`timescale 1ns/100ps
module tb;
  import sbda_pkg::*;
  logic clk_sys_in, nrst_in, cpu16_idle_in, cpu16_handover_sel_in;
  logic cpu8_idle_in, cpu8_io_req_in, irq_in, master_hold_req_in;
  logic slave_hold_req_in, cascade_dack_in, dma_high_address_strobe_in;
  logic dma_refresh_in, bank_wr_in, slow_io_in, bus_wait_extend_in;
  logic floppy_cycle_in, cpu16_run_out, cpu8_run_out, master_hold_ack_out;
  logic master_drive_en_out, sys_drive_en_out, data_xfer_en_out;
  logic onboard_io_en_out, cascade_dreq_out, cpu16_ready_out;
  logic dma_ready_out, cpu16_clk_out, cpu8_clk_out, dma_clk_out;
  logic [SYS_W-1:0] cpu16_addr_in, sys_addr_out;
  logic [LOC_W-1:0] cpu8_addr_in;
  logic [NUM_SPARE-1:0] spare_dack_in, spare_passive_in, offboard_req_in;
  logic [NUM_SPARE-1:0] spare_dreq_out, last_req;
  logic [BYTE_W-1:0] dma_data_in, dma_addr_lo_in;
  logic [1:0] dma_chan_in, lag;
  logic [2:0] bank_sel_in;
  logic [BANK_W-1:0] bank_data_in;
  logic [BANK_W-1:0] bank_m [0:4];
  logic own8_m;
  int n_fail = 0;
  int n_checks = 0;

  sbda_top dut_u (.clk_sys_in, .nrst_in, .cpu16_idle_in,
    .cpu16_handover_sel_in, .cpu16_addr_in, .cpu8_idle_in, .cpu8_io_req_in,
    .cpu8_addr_in, .irq_in, .master_hold_req_in, .slave_hold_req_in,
    .cascade_dack_in, .spare_dack_in, .spare_passive_in, .offboard_req_in,
    .dma_high_address_strobe_in, .dma_data_in, .dma_addr_lo_in,
    .dma_chan_in, .dma_refresh_in, .bank_wr_in, .bank_sel_in, .bank_data_in,
    .slow_io_in, .bus_wait_extend_in, .floppy_cycle_in, .cpu16_run_out,
    .cpu8_run_out, .master_hold_ack_out, .master_drive_en_out,
    .sys_drive_en_out, .data_xfer_en_out, .onboard_io_en_out,
    .cascade_dreq_out, .spare_dreq_out, .sys_addr_out, .cpu16_ready_out,
    .dma_ready_out, .cpu16_clk_out, .cpu8_clk_out, .dma_clk_out);
  sbda_cpu_model cpu_u (.clk_sys_in, .run16_in(cpu16_run_out),
    .run8_in(cpu8_run_out), .lag_in(lag), .idle16_out(cpu16_idle_in),
    .idle8_out(cpu8_idle_in));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [SYS_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return cpu16_run_out;
      1: return cpu8_run_out;
      2: return master_hold_ack_out;
      4: return cpu16_clk_out;
      5: return cpu8_clk_out;
      default: return dma_clk_out;
    endcase
  endfunction

  task automatic await(input int k, input logic v);
    int i;
    i = 0;
    while (pick(k) !== v && i < 60) begin
      @(posedge clk_sys_in);
      #1;
      i++;
    end
    chk(pick(k), v);
  endtask

  task automatic wbank(input logic [2:0] s, input logic [3:0] d);
    @(posedge clk_sys_in);
    {bank_wr_in, bank_sel_in, bank_data_in} <= {1'b1, s, d};
    if (s < 3'h5) bank_m[s] = d;
    @(posedge clk_sys_in);
    bank_wr_in <= 1'b0;
  endtask

  task automatic swap(input int c);
    @(posedge clk_sys_in);
    case (c)
      0: cpu16_handover_sel_in <= 1'b1;
      1: irq_in <= 1'b1;
      default: cpu8_io_req_in <= 1'b1;
    endcase
    await(c == 0 ? 1 : 0, 1'b1);
    chk(pick(c == 0 ? 0 : 1), 1'b0);
    @(posedge clk_sys_in);
    {cpu16_handover_sel_in, irq_in, cpu8_io_req_in} <= 3'h0;
    own8_m = (c == 0);
    $display("test swap %0d done", c);
  endtask

  task automatic dma(input logic casc, refr, pas);
    logic [7:0] hi;
    logic [7:0] lo;
    logic [1:0] ch;
    hi = 8'($urandom);
    lo = 8'($urandom);
    ch = 2'($urandom);
    @(posedge clk_sys_in);
    lag <= 2'($urandom);
    slave_hold_req_in <= casc;
    #1 chk(cascade_dreq_out, 1'b0);
    @(posedge clk_sys_in);
    master_hold_req_in <= 1'b1;
    #1 chk(cascade_dreq_out, casc);
    await(2, 1'b1);
    chk({cpu16_run_out, cpu8_run_out}, 2'h0);
    @(posedge clk_sys_in);
    {cascade_dack_in, dma_refresh_in, dma_chan_in, dma_addr_lo_in} <=
      {casc, refr, ch, lo};
    {dma_high_address_strobe_in, dma_data_in} <= {1'b1, hi};
    spare_passive_in <= {NUM_SPARE{pas}};
    spare_dack_in <= casc ? 4'h0 : 4'h1 << ch;
    @(posedge clk_sys_in);
    {dma_high_address_strobe_in, dma_data_in} <= {1'b0, ~hi};
    repeat (3) @(posedge clk_sys_in);
    #1 chk(sys_addr_out, {bank_m[ch], hi, lo});
    chk(data_xfer_en_out, !refr);
    chk(sys_drive_en_out, !pas);
    if (pas) chk(onboard_io_en_out, 1'b0);
    else chk(master_drive_en_out, !casc);
    @(posedge clk_sys_in);
    {master_hold_req_in, slave_hold_req_in, cascade_dack_in} <= 3'h0;
    spare_dack_in <= 4'h0;
    @(posedge clk_sys_in);
    #1 chk(cascade_dreq_out, 1'b0);
    await(2, 1'b0);
    chk(pick(own8_m ? 1 : 0), 1'b1);
    $display("test dma %b%b%b done", casc, refr, pas);
  endtask

  task automatic period(input int k, input int p);
    int t[$];
    logic o;
    o = pick(k);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (!o && pick(k)) t.push_back(i);
      o = pick(k);
    end
    chk(20'(t[1] - t[0]), 20'(p));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    n_fail++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(32'h57c5));
    {nrst_in, cpu16_handover_sel_in, cpu16_addr_in, cpu8_io_req_in} = '0;
    {cpu8_addr_in, irq_in, master_hold_req_in, slave_hold_req_in} = '0;
    {cascade_dack_in, spare_dack_in, spare_passive_in, offboard_req_in} = '0;
    {dma_high_address_strobe_in, dma_data_in, dma_addr_lo_in} = '0;
    {dma_chan_in, dma_refresh_in, bank_wr_in, bank_sel_in} = '0;
    {bank_data_in, slow_io_in, bus_wait_extend_in, floppy_cycle_in} = '0;
    {lag, own8_m} = '0;
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    #1 chk({cpu16_run_out, master_hold_ack_out}, 2'h2);
    @(posedge clk_sys_in);
    #1 chk({cpu16_run_out, cpu8_run_out}, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 8; i++) wbank(3'(i), 4'($urandom));
    for (int r = 0; r < 8; r++) dma(r[0], r[1], r[2] & ~r[0]);
    swap(0);
    @(posedge clk_sys_in);
    cpu8_addr_in <= 16'($urandom);
    repeat (3) @(posedge clk_sys_in);
    #1 chk(sys_addr_out, {bank_m[4], cpu8_addr_in});
    dma(1'b0, 1'b0, 1'b0);
    swap(1);
    swap(0);
    swap(2);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys_in);
      last_req = offboard_req_in;
      offboard_req_in <= 4'($urandom);
      #1 if (i > 0) chk(spare_dreq_out, last_req);
    end
    $display("test offboard done");
    @(posedge clk_sys_in);
    slow_io_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    {slow_io_in, bus_wait_extend_in} <= 2'h1;
    #1 chk({cpu16_ready_out, dma_ready_out}, 2'h0);
    repeat (5) @(posedge clk_sys_in);
    bus_wait_extend_in <= 1'b0;
    #1 chk({cpu16_ready_out, dma_ready_out}, 2'h2);
    repeat (3) @(posedge clk_sys_in);
    floppy_cycle_in <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk_sys_in);
      floppy_cycle_in <= 1'b0;
      #1 n += int'(dma_ready_out === 1'b0);
    end
    chk(n >= 11 && n <= 20, 1'b1);
    chk(dma_ready_out, 1'b1);
    $display("test ready done");
    period(4, 5);
    period(5, 6);
    period(6, 10);
    $display("test clocks done");
    tally_and_finish();
  end
endmodule
